// file: pkg/mvi_pkg.sv
// mvi_pkg: constants shared by the vectored interrupt unit and its stack.
// assumes an ahb-lite register bus with byte addresses in the low bits.
package mvi_pkg;
   // sizes
   localparam int NSRC   = 15;
   localparam int NSUB   = 4;
   localparam int PC_W   = 13;
   localparam int STK_N  = 8;
   localparam int STK_AW = 3;
   localparam int SP_W   = 4;
   localparam int ADDR_W = 8;
   localparam int WIN_W  = 4;
   localparam int NPIN   = 2;
   localparam int EDGE_W = 2;
   localparam logic [SP_W-1:0] SP_FULL = 4'h8;

   // source index, also vector order (lowest index wins)
   localparam int S_INT0 = 0;
   localparam int S_TKM  = 1;
   localparam int S_TB0  = 2;
   localparam int S_CT0P = 3;
   localparam int S_CT0A = 4;
   localparam int S_PT0P = 5;
   localparam int S_PT0A = 6;
   localparam int S_IIC  = 7;
   localparam int S_EE   = 8;
   localparam int S_UART = 9;
   localparam int S_LVD  = 10;
   localparam int S_TB1  = 11;
   localparam int S_MF0  = 12;
   localparam int S_MF1  = 13;
   localparam int S_INT1 = 14;

   // timer sources held inside the multi-function groups
   localparam int U_CT1P = 0;
   localparam int U_CT1A = 1;
   localparam int U_PT1P = 2;
   localparam int U_PT1A = 3;

   // vector = base + index * 4
   localparam logic [PC_W-1:0] VEC_BASE = 13'h0004;
   localparam int VEC_SH = 2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_EDGE_SELECT_REG = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_INTC0 = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_INTC1 = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_INTC2 = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_INTC3 = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_MF_GROUP0_TIMER_IRQ  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_MF_GROUP1_TIMER_IRQ  = 8'h18;

   // multi-function register fields
   localparam int B_MF_AF = 5;
   localparam int B_MF_PF = 4;
   localparam int B_MF_AE = 1;
   localparam int B_MF_PE = 0;
   localparam int B_EMI   = 0;

   // edge select codes; bit 0 picks rising, bit 1 falling
   localparam logic [EDGE_W-1:0] EDGE_OFF = 2'h0;
   localparam int EDGE_RISE_BIT = 0;
   localparam int EDGE_FALL_BIT = 1;

   localparam logic [2:0] SIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_POP  = 2'b10
   } mvi_st_e;
endpackage

// file: pkg/mvi_stk_if.sv
// mvi_stk_if: write and read port of the return-address stack.
// assumes one writer and one reader in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface mvi_stk_if;
   import mvi_pkg::*;
   logic                we;
   logic [STK_AW-1:0]   waddr;
   logic [PC_W-1:0]     wdata;
   logic [STK_AW-1:0]   raddr;
   logic [PC_W-1:0]     rdata;
   modport ctl (output we, waddr, wdata, raddr, input rdata);
   modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// file: design/mvi_stack_mem.sv
// mvi_stack_mem: small stack store with registered read data.
// assumes the controller keeps the pointer and never overruns the depth.
`timescale 1ns/1ps
`default_nettype none
module mvi_stack_mem (
   // clock
   input wire logic   hclk,
   // stack port
   mvi_stk_if.mem     stk
);
   import mvi_pkg::*;

   logic [PC_W-1:0] mem_q [STK_N];

   // storage needs no reset, the pointer says what is valid
   always_ff @(posedge hclk) begin
      if (stk.we) begin
         mem_q[stk.waddr] <= stk.wdata;
      end
   end

   // read data is a flop, ready one cycle after the address
   always_ff @(posedge hclk) begin
      stk.rdata <= mem_q[stk.raddr];
   end
endmodule
`default_nettype wire

// file: design/mvi_irq_unit.sv
// mvi_irq_unit: vectored interrupt unit with return stack, ahb-lite registers.
// assumes core strobes are one-cycle pulses at instruction boundaries.
// Behaviour
// - source events set their flag whatever the enables say.
// - a set flag with its enable low never takes a vector.
// - global enable low blocks every vector.
// - accepting pushes the core pc and loads the vector address.
// - return from interrupt pops the saved pc and resumes there.
// - accepting clears the global enable.
// - flags keep latching while the global enable is low.
// - with the stack full nothing is accepted until a pop.
// - any flag becoming set wakes the core from sleep or idle.
// - vectors 04 pin0, 08 touch, 0C tb0, 10-1C timer0 matches.
// - vectors 20 to 3C; lowest address wins on a tie.
// - a pin flag sets only on the selected edge type.
// - edge code 00 off, 01 rising, 10 falling, 11 both.
// - servicing a pin clears its flag.
// - any group timer flag becoming set sets the group flag.
// - servicing a group clears the group flag.
// - group service leaves the timer flags; software clears them.
// - timer0 matches own vectors, timer1 matches feed the groups.
// - servicing a timer0 match clears its flag.
// - group registers hold a flag at 5,4 and enable at 1,0.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module mvi_irq_unit (
   // clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // ahb-lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic                        hready,
   input  wire logic [31:0]                 hwdata,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   // interrupt sources
   input  wire logic [mvi_pkg::NSRC-1:0]    periph_evt,
   input  wire logic [mvi_pkg::NSUB-1:0]    sub_evt,
   input  wire logic [mvi_pkg::NPIN-1:0]    ext_pin,
   // core side
   input  wire logic [mvi_pkg::PC_W-1:0]    core_pc,
   input  wire logic                        irq_ok,
   input  wire logic                        call_push,
   input  wire logic                        ret_pop,
   input  wire logic                        return_from_irq,
   input  wire logic                        sleep_mode,
   output logic                             vec_load,
   output logic      [mvi_pkg::PC_W-1:0]    vec_addr,
   output logic                             ret_load,
   output logic      [mvi_pkg::PC_W-1:0]    ret_pc,
   output logic                             stack_full,
   output logic                             wake
);
   import mvi_pkg::*;

   logic [NSRC-1:0]      fl_q, fl_d, en_q, set_ev, wfe, wfv, pend, clr;
   logic [NSUB-1:0]      sub_q, sub_d, sen_q, swe, swv;
   logic [NPIN*EDGE_W-1:0] edge_q;
   logic [NPIN-1:0]      pin_q, pin_hit;
   logic                 global_irq_enable;
   logic [SP_W-1:0]      sp_q, sp_dec;
   mvi_st_e              st_q;
   logic                 wr_q, rd_q, ap, mf_rise0, mf_rise1;
   logic [ADDR_W-1:0]    a_q;
   logic [7:0]           wb, rbyte;
   logic [31:0]          hrdata_q;
   logic [WIN_W-1:0]     win;
   logic                 any_pend, accept, do_pop, call_ok, full, win_en;
   logic [PC_W-1:0]      vec_q;
   logic                 vload_q, wake_q;

   mvi_stk_if stk ();

   mvi_stack_mem u_stack (
      .hclk (hclk),
      .stk  (stk.mem)
   );

   // bus answers: reads take one wait state so data comes from a flop
   assign hreadyout = ~rd_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign ap        = hsel & htrans[1] & hready;
   assign wb        = hwdata[7:0];

   // address phase capture; narrow writes are ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         a_q  <= '0;
      end else begin
         wr_q <= ap & hwrite & (hsize == SIZE_WORD);
         rd_q <= ap & ~hwrite;
         if (ap) begin
            a_q <= haddr[ADDR_W-1:0];
         end
      end
   end

   // read data register, loaded in the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (rd_q) begin
         hrdata_q <= {24'h000000, rbyte};
      end
   end

   // read map; unused bits and unmapped offsets read zero
   always_comb begin
      case (a_q)
         OFF_EDGE_SELECT_REG: rbyte = {4'h0, edge_q};
         OFF_INTC0: rbyte = {1'b0, fl_q[S_TB0], fl_q[S_TKM], fl_q[S_INT0],
                             en_q[S_TB0], en_q[S_TKM], en_q[S_INT0], global_irq_enable};
         OFF_INTC1: rbyte = {fl_q[S_PT0A], fl_q[S_PT0P], fl_q[S_CT0A], fl_q[S_CT0P],
                             en_q[S_PT0A], en_q[S_PT0P], en_q[S_CT0A], en_q[S_CT0P]};
         OFF_INTC2: rbyte = {fl_q[S_LVD], fl_q[S_UART], fl_q[S_EE], fl_q[S_IIC],
                             en_q[S_LVD], en_q[S_UART], en_q[S_EE], en_q[S_IIC]};
         OFF_INTC3: rbyte = {fl_q[S_INT1], fl_q[S_MF1], fl_q[S_MF0], fl_q[S_TB1],
                             en_q[S_INT1], en_q[S_MF1], en_q[S_MF0], en_q[S_TB1]};
         OFF_MF_GROUP0_TIMER_IRQ:  rbyte = {2'h0, sub_q[U_CT1A], sub_q[U_CT1P],
                             2'h0, sen_q[U_CT1A], sen_q[U_CT1P]};
         OFF_MF_GROUP1_TIMER_IRQ:  rbyte = {2'h0, sub_q[U_PT1A], sub_q[U_PT1P],
                             2'h0, sen_q[U_PT1A], sen_q[U_PT1P]};
         default:   rbyte = 8'h00;
      endcase
   end

   // software writes to flags, merged below with hardware sets and clears
   always_comb begin
      wfe = '0;
      wfv = '0;
      swe = '0;
      swv = '0;
      if (wr_q) begin
         case (a_q)
            OFF_INTC0: begin
               {wfe[S_TB0], wfe[S_TKM], wfe[S_INT0]} = 3'h7;
               {wfv[S_TB0], wfv[S_TKM], wfv[S_INT0]} = wb[6:4];
            end
            OFF_INTC1: begin
               {wfe[S_PT0A], wfe[S_PT0P], wfe[S_CT0A], wfe[S_CT0P]} = 4'hF;
               {wfv[S_PT0A], wfv[S_PT0P], wfv[S_CT0A], wfv[S_CT0P]} = wb[7:4];
            end
            OFF_INTC2: begin
               {wfe[S_LVD], wfe[S_UART], wfe[S_EE], wfe[S_IIC]} = 4'hF;
               {wfv[S_LVD], wfv[S_UART], wfv[S_EE], wfv[S_IIC]} = wb[7:4];
            end
            OFF_INTC3: begin
               {wfe[S_INT1], wfe[S_MF1], wfe[S_MF0], wfe[S_TB1]} = 4'hF;
               {wfv[S_INT1], wfv[S_MF1], wfv[S_MF0], wfv[S_TB1]} = wb[7:4];
            end
            OFF_MF_GROUP0_TIMER_IRQ: begin
               {swe[U_CT1A], swe[U_CT1P]} = 2'h3;
               {swv[U_CT1A], swv[U_CT1P]} = {wb[B_MF_AF], wb[B_MF_PF]};
            end
            OFF_MF_GROUP1_TIMER_IRQ: begin
               {swe[U_PT1A], swe[U_PT1P]} = 2'h3;
               {swv[U_PT1A], swv[U_PT1P]} = {wb[B_MF_AF], wb[B_MF_PF]};
            end
            default: ;
         endcase
      end
   end

   // enable and edge-select registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_q   <= '0;
         sen_q  <= '0;
         edge_q <= '0;
      end else if (wr_q) begin
         case (a_q)
            OFF_EDGE_SELECT_REG: edge_q <= wb[NPIN*EDGE_W-1:0];
            OFF_INTC0: {en_q[S_TB0], en_q[S_TKM], en_q[S_INT0]} <= wb[3:1];
            OFF_INTC1: {en_q[S_PT0A], en_q[S_PT0P], en_q[S_CT0A], en_q[S_CT0P]} <= wb[3:0];
            OFF_INTC2: {en_q[S_LVD], en_q[S_UART], en_q[S_EE], en_q[S_IIC]} <= wb[3:0];
            OFF_INTC3: {en_q[S_INT1], en_q[S_MF1], en_q[S_MF0], en_q[S_TB1]} <= wb[3:0];
            OFF_MF_GROUP0_TIMER_IRQ: begin
               sen_q[U_CT1A] <= wb[B_MF_AE];
               sen_q[U_CT1P] <= wb[B_MF_PE];
            end
            OFF_MF_GROUP1_TIMER_IRQ: begin
               sen_q[U_PT1A] <= wb[B_MF_AE];
               sen_q[U_PT1P] <= wb[B_MF_PE];
            end
            default: ;
         endcase
      end
   end

   // pin edge detect; pins are already synchronous to hclk
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_q <= '0;
      end else begin
         pin_q <= ext_pin;
      end
   end

   for (genvar p = 0; p < NPIN; p++) begin : g_pin
      logic [EDGE_W-1:0] sel;
      assign sel = edge_q[p*EDGE_W +: EDGE_W];
      assign pin_hit[p] = (ext_pin[p] & ~pin_q[p] & sel[EDGE_RISE_BIT])
                        | (~ext_pin[p] & pin_q[p] & sel[EDGE_FALL_BIT]);
   end

   // timer1 flags: a new event beats a software clear in the same cycle
   for (genvar j = 0; j < NSUB; j++) begin : g_sub
      assign sub_d[j] = sub_evt[j] | (swe[j] ? swv[j] : sub_q[j]);
   end
   assign mf_rise0 = |(sub_d[U_CT1A:U_CT1P] & ~sub_q[U_CT1A:U_CT1P]);
   assign mf_rise1 = |(sub_d[U_PT1A:U_PT1P] & ~sub_q[U_PT1A:U_PT1P]);

   // hardware set sources per vector
   always_comb begin
      set_ev         = periph_evt;
      set_ev[S_INT0] = pin_hit[0];
      set_ev[S_INT1] = pin_hit[1];
      set_ev[S_MF0]  = mf_rise0;
      set_ev[S_MF1]  = mf_rise1;
   end

   // set wins over software write and over the service clear
   for (genvar i = 0; i < NSRC; i++) begin : g_flag
      assign fl_d[i] = set_ev[i] | (wfe[i] ? wfv[i] : (fl_q[i] & ~clr[i]));
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fl_q  <= '0;
         sub_q <= '0;
      end else begin
         fl_q  <= fl_d;
         sub_q <= sub_d;
      end
   end

   // fixed priority, index 0 highest, so the lowest vector wins
   always_comb begin
      pend = fl_q & en_q;
      win  = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            win = WIN_W'(i);
         end
      end
   end

   assign any_pend = |pend;
   assign win_en   = en_q[win] & fl_q[win];
   assign full     = (sp_q == SP_FULL);
   assign sp_dec   = sp_q - 4'h1;
   assign do_pop   = (ret_pop | return_from_irq) & (sp_q != '0) & (st_q == ST_IDLE);
   assign call_ok  = call_push & ~full & ~ret_pop & ~return_from_irq;
   // core strobes take the cycle; a request simply waits for the next one
   assign accept   = irq_ok & global_irq_enable & any_pend & ~full & (st_q == ST_IDLE)
                   & ~call_push & ~ret_pop & ~return_from_irq;
   assign clr      = accept ? (NSRC'(1) << win) : '0;

   // stack port: push the core pc, pop reads below the pointer
   assign stk.we    = accept | call_ok;
   assign stk.waddr = sp_q[STK_AW-1:0];
   assign stk.wdata = core_pc;
   assign stk.raddr = sp_dec[STK_AW-1:0];

   // stack pointer, saturates at full
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_q <= '0;
      end else if (do_pop) begin
         sp_q <= sp_dec;
      end else if (stk.we) begin
         sp_q <= sp_q + 4'h1;
      end
   end

   // pop sequencing, one cycle for the registered stack read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: if (do_pop) st_q <= ST_POP;
            ST_POP:  st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // global enable: service clears it, return sets it again
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         global_irq_enable <= 1'b0;
      end else if (accept) begin
         global_irq_enable <= 1'b0;
      end else if (do_pop & return_from_irq) begin
         global_irq_enable <= 1'b1;
      end else if (wr_q && a_q == OFF_INTC0) begin
         global_irq_enable <= wb[B_EMI];
      end
   end

   // vector load and wake pulses
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vload_q <= 1'b0;
         vec_q   <= '0;
         wake_q  <= 1'b0;
      end else begin
         vload_q <= accept;
         if (accept) begin
            vec_q <= VEC_BASE + (PC_W'(win) << VEC_SH);
         end
         wake_q <= sleep_mode & (|(fl_d & ~fl_q) | |(sub_d & ~sub_q));
      end
   end

   assign vec_load   = vload_q;
   assign vec_addr   = vec_q;
   assign ret_load   = (st_q == ST_POP);
   assign ret_pc     = stk.rdata;
   assign stack_full = full;
   assign wake       = wake_q;

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_return_from_irq_req; do_pop && return_from_irq; endsequence
   sequence s_resume; ret_load ##1 !ret_load; endsequence

   property p_gemi; !global_irq_enable |=> !vload_q; endproperty
   a_gemi: assert property (p_gemi) else $error("vector with global enable low");
   property p_en; vload_q |-> $past(win_en); endproperty
   a_en: assert property (p_en) else $error("vector for a disabled source");
   property p_nest; vload_q |-> !global_irq_enable; endproperty
   a_nest: assert property (p_nest) else $error("global enable left set");
   property p_full; full |=> !vload_q; endproperty
   a_full: assert property (p_full) else $error("vector taken with stack full");
   property p_vec; vload_q |-> (vec_q == VEC_BASE + (PC_W'($past(win)) << VEC_SH)); endproperty
   a_vec: assert property (p_vec) else $error("wrong vector address");
   property p_push; vload_q |-> sp_q == $past(sp_q) + 4'h1; endproperty
   a_push: assert property (p_push) else $error("pc not pushed");
   property p_return_from_irq; s_return_from_irq_req |=> s_resume; endproperty
   a_return_from_irq: assert property (p_return_from_irq) else $error("return did not resume");
   property p_latch; periph_evt[S_UART] |=> fl_q[S_UART]; endproperty
   a_latch: assert property (p_latch) else $error("event not latched");
   property p_wake; sleep_mode && |(fl_d & ~fl_q) |=> wake; endproperty
   a_wake: assert property (p_wake) else $error("no wake on new flag");
   property p_mf; mf_rise0 |=> fl_q[S_MF0]; endproperty
   a_mf: assert property (p_mf) else $error("group flag not set");
   property p_clr; accept && !set_ev[win] && !wfe[win] |=> !fl_q[$past(win)]; endproperty
   a_clr: assert property (p_clr) else $error("serviced flag not cleared");
   property p_off;
      edge_q[EDGE_W-1:0] == EDGE_OFF && !fl_q[S_INT0] && !wfe[S_INT0] |=> !fl_q[S_INT0];
   endproperty
   a_off: assert property (p_off) else $error("pin flag set while disabled");
   property p_keep;
      accept && win == WIN_W'(S_MF0) && swe == '0 && sub_evt == '0 |=> sub_q == $past(sub_q);
   endproperty
   a_keep: assert property (p_keep) else $error("group timer flags changed");
endmodule
`default_nettype wire

// file: testbench/mvi_core_model.sv
// mvi_core_model: behavioural core sequencer facing the interrupt unit.
// assumes the unit gives registered load pulses on hclk.
`timescale 1ns/1ps
`default_nettype none
module mvi_core_model #(
   parameter logic [mvi_pkg::PC_W-1:0] PC_START = 13'h0100
) (
   // clock and reset
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   // unit side
   input  wire logic                     vec_load,
   input  wire logic [mvi_pkg::PC_W-1:0] vec_addr,
   input  wire logic                     ret_load,
   input  wire logic [mvi_pkg::PC_W-1:0] ret_pc,
   input  wire logic                     sleep_mode,
   output logic                          irq_ok,
   output logic      [mvi_pkg::PC_W-1:0] core_pc
);
   import mvi_pkg::*;
   // a sleeping core sits at no instruction boundary
   assign irq_ok = !sleep_mode;
   // pc holds still between loads so every pushed address is predictable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         core_pc <= PC_START;
      else if (vec_load)
         core_pc <= vec_addr;
      else if (ret_load)
         core_pc <= ret_pc;
   end
endmodule
`default_nettype wire

// file: testbench/mvi_irq_unit_tb.sv
// mvi_irq_unit_tb: self-checking bench for the vectored interrupt unit.
// assumes one ahb-lite master and the core model on the far side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module mvi_irq_unit_tb;
   import mvi_pkg::*;
   typedef struct {int kind; logic [31:0] val;} mvi_note_s;
   localparam logic [PC_W-1:0] PC0 = 13'h0100;
   logic                hclk = 1'b0;
   logic                hresetn, hsel, hwrite, hreadyout, hresp, irq_ok, rd_pend;
   logic                call_push, ret_pop, return_from_irq, sleep_mode;
   logic                vec_load, ret_load, stack_full, wake;
   logic [31:0]         haddr, hwdata, hrdata;
   logic [1:0]          htrans, ext_pin;
   logic [2:0]          hsize;
   logic [NSRC-1:0]     periph_evt, ev;
   logic [NSUB-1:0]     sub_evt;
   logic [PC_W-1:0]     core_pc, vec_addr, ret_pc;
   int                  failures, checks_done;
   mvi_note_s           q[$];

   mvi_irq_unit u_mvi_irq_unit (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .periph_evt, .sub_evt,
      .ext_pin, .core_pc, .irq_ok, .call_push, .ret_pop, .return_from_irq, .sleep_mode,
      .vec_load, .vec_addr, .ret_load, .ret_pc, .stack_full, .wake);
   mvi_core_model #(.PC_START(PC0)) u_mvi_core_model (.hclk, .hresetn, .vec_load,
      .vec_addr, .ret_load, .ret_pc, .sleep_mode, .irq_ok, .core_pc);

   // 125 MHz
   always #4 hclk = ~hclk;

   task automatic final_report();
      $display("checks_done %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge hclk);
   endtask

   // bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         failures++;
         final_report();
      end
   endtask

   // one single-word transfer; address phase held until hready, then data phase
   task automatic bus(logic [7:0] a, logic wr, logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
   endtask

   task automatic note(int k, logic [31:0] v);
      q.push_back('{k, v});
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] e);
      note(0, {24'h0, e});
      bus(a, 1'b0, 8'h00);
   endtask

   // wait until the monitor has consumed every note
   task automatic drain();
      int n;
      n = 0;
      while (q.size() != 0 && n < 300) begin
         @(posedge hclk);
         n++;
      end
      if (q.size() != 0) begin
         failures++;
         final_report();
      end
   endtask

   // core strobes: 0 call, 1 pop, 2 return from interrupt; idle edge after
   task automatic strobe(int s);
      case (s)
         0: call_push <= 1'b1;
         1: ret_pop <= 1'b1;
         default: return_from_irq <= 1'b1;
      endcase
      tick(1);
      {call_push, ret_pop, return_from_irq} <= 3'h0;
      tick(1);
   endtask

   task automatic pulse(logic [NSRC-1:0] p, logic [NSUB-1:0] s);
      periph_evt <= p;
      sub_evt <= s;
      tick(1);
      periph_evt <= '0;
      sub_evt <= '0;
      tick(1);
   endtask

   task automatic do_reset();
      hresetn <= 1'b0;
      tick(16);
      hresetn <= 1'b1;
      tick(1);
   endtask

   // register holding a source, and its flag and enable bits
   function automatic logic [7:0] sreg(int i);
      return (i < 3) ? OFF_INTC0 : 8'(OFF_INTC1 + 8'(4 * ((i - 3) / 4)));
   endfunction
   function automatic logic [7:0] sbits(int i);
      return (i < 3) ? 8'h09 << (i + 1) : 8'h11 << ((i - 3) % 4);
   endfunction

   // compares each result in order of appearance against the oldest note
   task automatic take(int k, logic [31:0] g);
      mvi_note_s n;
      if (q.size() == 0 || q[0].kind != k) begin
         failures++;
         $display("unexpected result kind %0d: expected none seen %h", k, g);
      end else begin
         n = q.pop_front();
         `CHK($sformatf("result kind %0d", k), n.val, g)
      end
   endtask

   // monitor: values seen at the edge are the settled pre-edge outputs
   always @(posedge hclk) begin
      if (!hresetn)
         rd_pend = 1'b0;
      else begin
         if (rd_pend && hreadyout) take(0, hrdata);
         if (vec_load) take(1, {19'h0, vec_addr});
         if (ret_load) take(2, {19'h0, ret_pc});
         if (wake) take(3, 32'h1);
         if (hreadyout) rd_pend = hsel && htrans[1] && !hwrite;
      end
   end

   initial begin
      logic [7:0] r, m;
      int b;
      bit first;
      {hsel, hwrite, call_push, ret_pop, return_from_irq, sleep_mode} = 6'h00;
      haddr = '0;
      hwdata = '0;
      htrans = 2'h0;
      hsize = SIZE_WORD;
      periph_evt = '0;
      sub_evt = '0;
      ext_pin = 2'h0;
      hresetn = 1'b0;
      failures = 0;
      checks_done = 0;
      void'($urandom(32'h7308));
      do_reset();
      // reset values, unmapped place, unused bits of a group register
      for (int a = 0; a < 8; a++)
         rd(8'(4 * a), 8'h00);
      `CHK("hresp", 1'b0, hresp)
      wr(OFF_MF_GROUP0_TIMER_IRQ, 8'hFF);
      rd(OFF_MF_GROUP0_TIMER_IRQ, 8'h33);
      rd(OFF_INTC3, 8'h20);
      wr(OFF_MF_GROUP0_TIMER_IRQ, 8'h00);
      wr(OFF_INTC3, 8'h00);
      // every edge code on both pins
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 4; c++) begin
            r = p ? OFF_INTC3 : OFF_INTC0;
            b = p ? 7 : 4;
            wr(OFF_EDGE_SELECT_REG, 8'(c << (2 * p)));
            ext_pin[p] <= 1'b1;
            tick(2);
            rd(r, 8'(c & 1) << b);
            wr(r, 8'h00);
            ext_pin[p] <= 1'b0;
            tick(2);
            rd(r, 8'(c >> 1) << b);
            wr(r, 8'h00);
         end
      // each source alone: vector, auto clear, return
      for (int i = 0; i < NSRC; i++) begin
         r = sreg(i);
         m = sbits(i);
         wr(r, m);
         note(1, 32'(4 * i + 4));
         wr(OFF_INTC0, (i < 3) ? m | 8'h01 : 8'h01);
         drain();
         rd(r, m & 8'h0F);
         note(2, 32'(PC0));
         strobe(2);
         drain();
         wr(r, 8'h00);
         wr(OFF_INTC0, 8'h00);
      end
      // random simultaneous events latch with global enable off, then resolve
      do_reset();
      wr(OFF_INTC1, 8'h0F);
      wr(OFF_INTC2, 8'h0F);
      wr(OFF_INTC3, 8'h01);
      for (int k = 0; k < 4; k++) begin
         wr(OFF_INTC0, 8'h0E);
         ev = 15'($urandom & 32'h0FFE);
         ev[1] = ev[1] | (ev == '0);
         pulse(ev, '0);
         first = 1'b1;
         for (int i = 1; i < 12; i++)
            if (ev[i]) begin
               if (!first) note(2, 32'(PC0));
               note(1, 32'(4 * i + 4));
               if (first) wr(OFF_INTC0, 8'h0F | {1'b0, ev[2:1], 5'h00});
               else strobe(2);
               first = 1'b0;
               drain();
            end
         note(2, 32'(PC0));
         strobe(2);
         drain();
      end
      // flag without enable, then enable, then nesting
      do_reset();
      pulse(15'h0002, '0);
      wr(OFF_INTC0, 8'h21);
      tick(10);
      rd(OFF_INTC0, 8'h21);
      note(1, 32'h08);
      wr(OFF_INTC0, 8'h25);
      drain();
      note(2, 32'(PC0));
      strobe(2);
      drain();
      note(1, 32'h0C);
      wr(OFF_INTC0, 8'h4D);
      drain();
      note(1, 32'h08);
      wr(OFF_INTC0, 8'h2D);
      drain();
      note(2, 32'h0C);
      strobe(2);
      note(2, 32'(PC0));
      strobe(2);
      drain();
      // full stack holds the request until a pop
      do_reset();
      for (int k = 0; k < STK_N; k++)
         strobe(0);
      `CHK("stack_full", 1'b1, stack_full)
      wr(OFF_INTC0, 8'h25);
      tick(10);
      note(2, 32'(PC0));
      note(1, 32'h08);
      strobe(1);
      drain();
      // group flags follow timer1 events; service clears only the group flag
      do_reset();
      pulse('0, 4'h1 << U_CT1P);
      rd(OFF_MF_GROUP0_TIMER_IRQ, 8'h10);
      rd(OFF_INTC3, 8'h20);
      pulse('0, 4'h1 << U_PT1A);
      rd(OFF_MF_GROUP1_TIMER_IRQ, 8'h20);
      rd(OFF_INTC3, 8'h60);
      wr(OFF_INTC3, 8'h64);
      note(1, 32'h38);
      wr(OFF_INTC0, 8'h01);
      drain();
      rd(OFF_INTC3, 8'h24);
      rd(OFF_MF_GROUP1_TIMER_IRQ, 8'h20);
      // wake from sleep on a new flag, none on a flag already set
      do_reset();
      sleep_mode <= 1'b1;
      tick(1);
      note(3, 32'h1);
      pulse(15'h1 << S_UART, '0);
      drain();
      pulse(15'h1 << S_UART, '0);
      tick(5);
      sleep_mode <= 1'b0;
      drain();
      final_report();
   end
endmodule
`undef CHK
`default_nettype wire
